// *** ssd_decoder.v ***
// setup state packet decoder with wishbone register view
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ssd_map.vh"
module ssd_decoder #(
  parameter NUM_ATTR = 32
) (
  // clock and reset
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // packet dword stream from command streamer
  input wire PKT_VALID_IN,
  input wire [31:0] PKT_DATA_IN,
  output wire PKT_READY_OUT,
  // wishbone slave
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [3:0] WB_SEL_IN,
  input wire [31:0] WB_DAT_IN,
  output reg [31:0] WB_DAT_OUT,
  output reg WB_ACK_OUT,
  // rasterizer state
  output reg [1:0] MS_RAST_MODE_OUT,
  output reg LAST_PIXEL_OUT,
  output reg [2:0] TRI_PV_OUT,
  output reg [1:0] LINE_PV_OUT,
  output reg [2:0] FAN_PV_OUT,
  output reg AA_DIST_NORMAL_OUT,
  output reg [3:0] SUBPIX_BITS_OUT,
  output reg [10:0] STATE_PT_WIDTH_OUT,
  output reg [31:0] DEPTH_CONST_OUT,
  output reg [31:0] DEPTH_SCALE_OUT,
  output reg [31:0] DEPTH_CLAMP_OUT,
  // per primitive point width selection
  input wire VTX_PTW_VALID_IN,
  input wire [10:0] VTX_PTW_IN,
  output reg [10:0] POINT_WIDTH_OUT,
  // line pixel lighting
  input wire LINE_IS_THIN_IN,
  input wire LINE_IS_LAST_SEG_IN,
  output reg LIGHT_LAST_PIXEL_OUT,
  // backend state
  output reg [5:0] NUM_ATTR_OUT,
  output reg SWZ_EN_OUT,
  output reg SWZ_HALF_OUT,
  output reg SPRITE_ORIGIN_OUT,
  output reg [NUM_ATTR-1:0] SWZ_MASK_OUT,
  output reg PKT_ERR_OUT
);
  localparam ST_HDR = 4'b0001;
  localparam ST_SETUP = 4'b0010;
  localparam ST_BACKEND = 4'b0100;
  localparam ST_SKIP = 4'b1000;

  // header match helper, used for both packets
  function hdr_match;
    input [31:0] d;
    input [7:0] sub;
    begin
      hdr_match = (d[31:29] == `SSD_TYPE_GFX) && (d[28:27] == `SSD_SUBTYPE_3D) &&
                  (d[26:24] == `SSD_OPC_PIPELINED) && (d[23:16] == sub);
    end
  endfunction

  // reserved provoking vertex codes keep the previous selection
  function pv_ok;
    input [1:0] code;
    input [1:0] max;
    begin
      pv_ok = (code <= max);
    end
  endfunction

  reg [3:0] state_q;
  reg [7:0] remain_q;
  reg [7:0] index_q;
  reg [31:0] ctrl_q;
  reg [15:0] pkt_count_q;
  reg [31:0] setup2_q;
  reg [31:0] setup3_q;
  reg [31:0] backend1_q;
  reg ptw_state_q;
  wire [NUM_ATTR-1:0] mask_w;
  wire enable_w = ctrl_q[`SSD_CTRL_ENABLE];
  wire take_w = PKT_VALID_IN & enable_w;
  wire last_w = (remain_q == 8'h00);
  wire wb_req_w = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  wire clr_err_w = wb_req_w & WB_WE_IN & (WB_ADR_IN == `SSD_REG_CTRL) & WB_SEL_IN[0] &
                   WB_DAT_IN[`SSD_CTRL_CLR_ERR];
  // disabled decoder stalls the streamer rather than dropping dwords
  assign PKT_READY_OUT = enable_w;

  ssd_attr_mask #(
    .NUM_ATTR(NUM_ATTR),
    .HALF(16)
  ) u_mask (
    .swz_en_in(SWZ_EN_OUT),
    .swz_half_in(SWZ_HALF_OUT),
    .num_attr_in(NUM_ATTR_OUT),
    .mask_out(mask_w)
  );

  // packet walker
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_HDR;
      remain_q <= 8'h00;
      index_q <= 8'h00;
      pkt_count_q <= 16'h0000;
      PKT_ERR_OUT <= 1'b0;
      setup2_q <= 32'h0000_0000;
      setup3_q <= 32'h0000_0000;
      backend1_q <= 32'h0000_0000;
      DEPTH_CONST_OUT <= 32'h0000_0000;
      DEPTH_SCALE_OUT <= 32'h0000_0000;
      DEPTH_CLAMP_OUT <= 32'h0000_0000;
      MS_RAST_MODE_OUT <= 2'h0;
      LAST_PIXEL_OUT <= 1'b0;
      TRI_PV_OUT <= 3'h1;
      LINE_PV_OUT <= 2'h1;
      FAN_PV_OUT <= 3'h1;
      AA_DIST_NORMAL_OUT <= 1'b0;
      SUBPIX_BITS_OUT <= `SSD_SUBPIX_HI;
      ptw_state_q <= 1'b0;
      STATE_PT_WIDTH_OUT <= 11'h000;
      NUM_ATTR_OUT <= 6'h00;
      SWZ_EN_OUT <= 1'b0;
      SWZ_HALF_OUT <= 1'b0;
      SPRITE_ORIGIN_OUT <= 1'b0;
    end else begin
      // set wins over software clear
      if (clr_err_w) begin
        PKT_ERR_OUT <= 1'b0;
      end
      if (take_w) begin
        case (state_q)
          ST_HDR: begin
            index_q <= 8'h01;
            // length excludes the header and one more dword, so it counts the rest minus one
            remain_q <= PKT_DATA_IN[7:0];
            pkt_count_q <= pkt_count_q + 16'h0001;
            if (hdr_match(PKT_DATA_IN, `SSD_SUB_BACKEND)) begin
              state_q <= ST_BACKEND;
            end else if (hdr_match(PKT_DATA_IN, `SSD_SUB_SETUP)) begin
              state_q <= ST_SETUP;
            end else begin
              state_q <= ST_SKIP;
              PKT_ERR_OUT <= 1'b1;
            end
          end
          ST_SETUP: begin
            index_q <= index_q + 8'h01;
            remain_q <= remain_q - 8'h01;
            if (last_w) begin
              state_q <= ST_HDR;
            end
            // reserved bits are simply not decoded
            case (index_q)
              8'h02: begin
                setup2_q <= PKT_DATA_IN;
                MS_RAST_MODE_OUT <= PKT_DATA_IN[`SSD_MSRAST_HI:`SSD_MSRAST_LO];
              end
              8'h03: begin
                setup3_q <= PKT_DATA_IN;
                LAST_PIXEL_OUT <= PKT_DATA_IN[`SSD_LAST_PIXEL];
                if (pv_ok(PKT_DATA_IN[`SSD_TRI_PV_HI:`SSD_TRI_PV_LO], 2'h2)) begin
                  TRI_PV_OUT <= 3'h1 << PKT_DATA_IN[`SSD_TRI_PV_HI:`SSD_TRI_PV_LO];
                end
                if (pv_ok(PKT_DATA_IN[`SSD_LINE_PV_HI:`SSD_LINE_PV_LO], 2'h1)) begin
                  LINE_PV_OUT <= 2'h1 << PKT_DATA_IN[`SSD_LINE_PV_HI:`SSD_LINE_PV_LO];
                end
                if (pv_ok(PKT_DATA_IN[`SSD_FAN_PV_HI:`SSD_FAN_PV_LO], 2'h2)) begin
                  FAN_PV_OUT <= 3'h1 << PKT_DATA_IN[`SSD_FAN_PV_HI:`SSD_FAN_PV_LO];
                end
                AA_DIST_NORMAL_OUT <= PKT_DATA_IN[`SSD_AA_DIST];
                SUBPIX_BITS_OUT <= PKT_DATA_IN[`SSD_SUBPIX_SEL] ? `SSD_SUBPIX_LO :
                                   `SSD_SUBPIX_HI;
                ptw_state_q <= PKT_DATA_IN[`SSD_PTW_STATE];
                STATE_PT_WIDTH_OUT <= PKT_DATA_IN[`SSD_PTW_HI:`SSD_PTW_LO];
              end
              // offset arithmetic is left downstream; the three terms pass through untouched
              8'h04: DEPTH_CONST_OUT <= PKT_DATA_IN;
              8'h05: DEPTH_SCALE_OUT <= PKT_DATA_IN;
              8'h06: DEPTH_CLAMP_OUT <= PKT_DATA_IN;
              default: begin
              end
            endcase
          end
          ST_BACKEND: begin
            index_q <= index_q + 8'h01;
            remain_q <= remain_q - 8'h01;
            if (last_w) begin
              state_q <= ST_HDR;
            end
            if (index_q == 8'h01) begin
              backend1_q <= PKT_DATA_IN;
              SWZ_HALF_OUT <= PKT_DATA_IN[`SSD_SWZ_HALF];
              NUM_ATTR_OUT <= PKT_DATA_IN[`SSD_NATTR_HI:`SSD_NATTR_LO];
              SWZ_EN_OUT <= PKT_DATA_IN[`SSD_SWZ_EN];
              SPRITE_ORIGIN_OUT <= PKT_DATA_IN[`SSD_SPRITE_ORG];
            end
          end
          ST_SKIP: begin
            remain_q <= remain_q - 8'h01;
            if (last_w) begin
              state_q <= ST_HDR;
            end
          end
          default: state_q <= ST_HDR;
        endcase
      end
    end
  end

  // per primitive outputs; state width register is never written here
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      POINT_WIDTH_OUT <= 11'h000;
      LIGHT_LAST_PIXEL_OUT <= 1'b0;
      SWZ_MASK_OUT <= {NUM_ATTR{1'b0}};
    end else begin
      if (VTX_PTW_VALID_IN && !ptw_state_q) begin
        POINT_WIDTH_OUT <= VTX_PTW_IN;
      end else begin
        POINT_WIDTH_OUT <= STATE_PT_WIDTH_OUT;
      end
      LIGHT_LAST_PIXEL_OUT <= LAST_PIXEL_OUT & LINE_IS_THIN_IN & LINE_IS_LAST_SEG_IN;
      // sprite and constant interpolation state is not in this mask
      SWZ_MASK_OUT <= mask_w;
    end
  end

  // wishbone slave: one wait state, ack for one cycle
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
      ctrl_q <= `SSD_CTRL_RESET;
    end else begin
      WB_ACK_OUT <= wb_req_w;
      if (wb_req_w && WB_WE_IN && WB_ADR_IN == `SSD_REG_CTRL && WB_SEL_IN[0]) begin
        ctrl_q <= {31'h0000_0000, WB_DAT_IN[`SSD_CTRL_ENABLE]};
      end
      if (wb_req_w && !WB_WE_IN) begin
        case (WB_ADR_IN)
          `SSD_REG_CTRL: WB_DAT_OUT <= ctrl_q;
          `SSD_REG_STATUS: WB_DAT_OUT <= {23'h000000, PKT_ERR_OUT, 4'h0, state_q};
          `SSD_REG_SETUP2: WB_DAT_OUT <= setup2_q;
          `SSD_REG_SETUP3: WB_DAT_OUT <= setup3_q;
          `SSD_REG_DEPTH_CONST: WB_DAT_OUT <= DEPTH_CONST_OUT;
          `SSD_REG_DEPTH_SCALE: WB_DAT_OUT <= DEPTH_SCALE_OUT;
          `SSD_REG_DEPTH_CLAMP: WB_DAT_OUT <= DEPTH_CLAMP_OUT;
          `SSD_REG_BACKEND1: WB_DAT_OUT <= backend1_q;
          `SSD_REG_PKT_COUNT: WB_DAT_OUT <= {16'h0000, pkt_count_q};
          default: WB_DAT_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ssd_decoder
`default_nettype wire

// *** ssd_map.vh ***
// constants for the setup state packet decoder
`ifndef SSD_MAP_VH
`define SSD_MAP_VH
// wishbone register byte offsets
`define SSD_REG_CTRL 8'h00
`define SSD_REG_STATUS 8'h04
`define SSD_REG_SETUP3 8'h08
`define SSD_REG_DEPTH_CONST 8'h0C
`define SSD_REG_DEPTH_SCALE 8'h10
`define SSD_REG_DEPTH_CLAMP 8'h14
`define SSD_REG_BACKEND1 8'h18
`define SSD_REG_SETUP2 8'h1C
`define SSD_REG_PKT_COUNT 8'h20
// control register bits
`define SSD_CTRL_ENABLE 0
`define SSD_CTRL_CLR_ERR 1
`define SSD_CTRL_RESET 32'h0000_0001
// header fields
`define SSD_TYPE_GFX 3'h3
`define SSD_SUBTYPE_3D 2'h3
`define SSD_OPC_PIPELINED 3'h0
`define SSD_SUB_SETUP 8'h13
`define SSD_SUB_BACKEND 8'h1F
`define SSD_BACKEND_LEN_DFLT 8'h0C
`define SSD_SETUP_LEN_DFLT 8'h05
// setup dword 2 fields
`define SSD_MSRAST_HI 9
`define SSD_MSRAST_LO 8
// setup dword 3 fields
`define SSD_LAST_PIXEL 31
`define SSD_TRI_PV_HI 30
`define SSD_TRI_PV_LO 29
`define SSD_LINE_PV_HI 28
`define SSD_LINE_PV_LO 27
`define SSD_FAN_PV_HI 26
`define SSD_FAN_PV_LO 25
`define SSD_AA_DIST 14
`define SSD_SUBPIX_SEL 12
`define SSD_PTW_STATE 11
`define SSD_PTW_HI 10
`define SSD_PTW_LO 0
// backend dword 1 fields
`define SSD_SWZ_HALF 28
`define SSD_NATTR_HI 27
`define SSD_NATTR_LO 22
`define SSD_SWZ_EN 21
`define SSD_SPRITE_ORG 20
// subpixel bit counts
`define SSD_SUBPIX_HI 4'h8
`define SSD_SUBPIX_LO 4'h4
`endif

// *** ssd_attr_mask.v ***
// per-attribute swizzle mask for the setup backend
`timescale 1ns/100ps
`default_nettype none
module ssd_attr_mask #(
  parameter NUM_ATTR = 32,
  parameter HALF = 16
) (
  // backend state
  input wire swz_en_in,
  input wire swz_half_in,
  input wire [5:0] num_attr_in,
  // mask out
  output wire [NUM_ATTR-1:0] mask_out
);
  genvar i;
  generate
    for (i = 0; i < NUM_ATTR; i = i + 1) begin : g_attr
      // only forwarded attributes of the selected half are swizzled
      wire in_half = swz_half_in ? (i >= HALF) : (i < HALF);
      wire fwd = (i < num_attr_in);
      assign mask_out[i] = swz_en_in & in_half & fwd;
    end
  endgenerate
endmodule // ssd_attr_mask
`default_nettype wire

// *** ssd_cs_model.sv ***
// command streamer model that feeds packet dwords to the decoder
`timescale 1ns/100ps
`default_nettype none
module ssd_cs_model (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [31:0] data_out
);
  logic [31:0] q [$];
  initial begin
    valid_out = 1'b0;
    data_out = 32'h0;
  end
  // a dword once offered is held until taken; idle data toggles so stale words never match
  always @(posedge clk_in) begin
    if (valid_out && ready_in)
      q.delete(0);
    if (!valid_out || ready_in) begin
      if (q.size() > 0 && $urandom_range(3) != 0) begin
        valid_out <= 1'b1;
        data_out <= q[0];
      end else begin
        valid_out <= 1'b0;
        data_out <= ~data_out;
      end
    end
  end
endmodule // ssd_cs_model
`default_nettype wire

// *** ssd_monitor.sv ***
// assertion checker for the setup state packet decoder
`timescale 1ns/100ps
`default_nettype none
module ssd_monitor #(parameter NUM_ATTR = 32) (
  // clock, reset, handshakes
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire PKT_VALID_IN,
  input wire PKT_READY_OUT,
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire WB_ACK_OUT,
  // decoded state
  input wire [2:0] TRI_PV_OUT,
  input wire [1:0] LINE_PV_OUT,
  input wire [2:0] FAN_PV_OUT,
  input wire [3:0] SUBPIX_BITS_OUT,
  input wire LAST_PIXEL_OUT,
  input wire [10:0] STATE_PT_WIDTH_OUT,
  input wire VTX_PTW_VALID_IN,
  input wire [10:0] POINT_WIDTH_OUT,
  input wire LINE_IS_THIN_IN,
  input wire LINE_IS_LAST_SEG_IN,
  input wire LIGHT_LAST_PIXEL_OUT,
  input wire [5:0] NUM_ATTR_OUT,
  input wire SWZ_EN_OUT,
  input wire SWZ_HALF_OUT,
  input wire SPRITE_ORIGIN_OUT,
  input wire [NUM_ATTR-1:0] SWZ_MASK_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [NUM_ATTR-1:0] m;
  wire lt = LAST_PIXEL_OUT && LINE_IS_THIN_IN && LINE_IS_LAST_SEG_IN;
  wire quiet = !(PKT_VALID_IN && PKT_READY_OUT) && !(WB_CYC_IN && WB_STB_IN && WB_WE_IN);
  always_comb
    for (int i = 0; i < NUM_ATTR; i++)
      m[i] = SWZ_EN_OUT && (SWZ_HALF_OUT ? i >= 16 : i < 16) && i < NUM_ATTR_OUT;
  sequence s_req; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT; endsequence
  sequence s_ack; WB_ACK_OUT ##1 !WB_ACK_OUT; endsequence
  property p_wb_ack; s_req |=> s_ack; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing");
  property p_pv; $onehot(TRI_PV_OUT) && $onehot(LINE_PV_OUT) && $onehot(FAN_PV_OUT); endproperty
  a_pv: assert property (p_pv) else $error("vertex select");
  property p_subpix; SUBPIX_BITS_OUT == 4'h4 || SUBPIX_BITS_OUT == 4'h8; endproperty
  a_subpix: assert property (p_subpix) else $error("subpixel count");
  property p_ptw; !VTX_PTW_VALID_IN |=> POINT_WIDTH_OUT == $past(STATE_PT_WIDTH_OUT); endproperty
  a_ptw: assert property (p_ptw) else $error("point width source");
  property p_kept; quiet |=> $stable({STATE_PT_WIDTH_OUT, LAST_PIXEL_OUT, TRI_PV_OUT}); endproperty
  a_kept: assert property (p_kept) else $error("state changed");
  property p_light; 1'b1 |=> LIGHT_LAST_PIXEL_OUT == $past(lt); endproperty
  a_light: assert property (p_light) else $error("last pixel");
  property p_mask; 1'b1 |=> SWZ_MASK_OUT == $past(m); endproperty
  a_mask: assert property (p_mask) else $error("swizzle mask");
  property p_hold; quiet |=> $stable({NUM_ATTR_OUT, SWZ_EN_OUT, SWZ_HALF_OUT}); endproperty
  a_hold: assert property (p_hold) else $error("backend changed");
endmodule // ssd_monitor
bind ssd_decoder ssd_monitor #(.NUM_ATTR(NUM_ATTR)) u_mon (
  .REF_CLK_IN(REF_CLK_IN),
  .RST_N_IN(RST_N_IN),
  .PKT_VALID_IN(PKT_VALID_IN),
  .PKT_READY_OUT(PKT_READY_OUT),
  .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN),
  .WB_WE_IN(WB_WE_IN),
  .WB_ACK_OUT(WB_ACK_OUT),
  .TRI_PV_OUT(TRI_PV_OUT),
  .LINE_PV_OUT(LINE_PV_OUT),
  .FAN_PV_OUT(FAN_PV_OUT),
  .SUBPIX_BITS_OUT(SUBPIX_BITS_OUT),
  .LAST_PIXEL_OUT(LAST_PIXEL_OUT),
  .STATE_PT_WIDTH_OUT(STATE_PT_WIDTH_OUT),
  .VTX_PTW_VALID_IN(VTX_PTW_VALID_IN),
  .POINT_WIDTH_OUT(POINT_WIDTH_OUT),
  .LINE_IS_THIN_IN(LINE_IS_THIN_IN),
  .LINE_IS_LAST_SEG_IN(LINE_IS_LAST_SEG_IN),
  .LIGHT_LAST_PIXEL_OUT(LIGHT_LAST_PIXEL_OUT),
  .NUM_ATTR_OUT(NUM_ATTR_OUT),
  .SWZ_EN_OUT(SWZ_EN_OUT),
  .SWZ_HALF_OUT(SWZ_HALF_OUT),
  .SPRITE_ORIGIN_OUT(SPRITE_ORIGIN_OUT),
  .SWZ_MASK_OUT(SWZ_MASK_OUT)
);
`default_nettype wire

// *** ssd_decoder_tb.sv ***
// self-checking bench for the setup state packet decoder
`timescale 1ns/100ps
`default_nettype none
module ssd_decoder_tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
  logic vv = 1'b0, thin = 1'b0, lseg = 1'b0, en, hf, org;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [10:0] vw = 11'h000;
  logic [31:0] wdat = 32'h0, r, d3, dep [3];
  logic [2:0] e_tri = 3'h1, e_fan = 3'h1, tpv, fpv;
  logic [1:0] e_line = 2'h1, mode, ms, lpv;
  logic [5:0] na, nao;
  wire pv, rdy, ack, lp, aa, light, se, sh, so, err;
  wire [31:0] pd, rdat, dc, ds, dcl, mask;
  wire [3:0] subp;
  wire [10:0] spw, pw;
  int errors = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  ssd_cs_model u_cs (.clk_in(clk), .ready_in(rdy), .valid_out(pv), .data_out(pd));
  ssd_decoder u_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .PKT_VALID_IN(pv), .PKT_DATA_IN(pd),
    .PKT_READY_OUT(rdy), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(wwe), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .MS_RAST_MODE_OUT(ms), .LAST_PIXEL_OUT(lp), .TRI_PV_OUT(tpv), .LINE_PV_OUT(lpv),
    .FAN_PV_OUT(fpv), .AA_DIST_NORMAL_OUT(aa), .SUBPIX_BITS_OUT(subp),
    .STATE_PT_WIDTH_OUT(spw), .DEPTH_CONST_OUT(dc), .DEPTH_SCALE_OUT(ds),
    .DEPTH_CLAMP_OUT(dcl), .VTX_PTW_VALID_IN(vv), .VTX_PTW_IN(vw), .POINT_WIDTH_OUT(pw),
    .LINE_IS_THIN_IN(thin), .LINE_IS_LAST_SEG_IN(lseg), .LIGHT_LAST_PIXEL_OUT(light),
    .NUM_ATTR_OUT(nao), .SWZ_EN_OUT(se), .SWZ_HALF_OUT(sh), .SPRITE_ORIGIN_OUT(so),
    .SWZ_MASK_OUT(mask), .PKT_ERR_OUT(err));
  task automatic finish_test;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= we;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    // request stands until ack is seen high at a rising edge; data is taken there
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    if (ack !== 1'b1) begin
      errors++;
      finish_test;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(negedge clk);
  endtask
  // wait until the streamer has handed over every queued dword
  task automatic drain;
    int k;
    k = 0;
    while ((u_cs.q.size() != 0 || pv) && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k >= 300) begin
      errors++;
      finish_test;
    end
    @(negedge clk);
  endtask
  function automatic logic [2:0] pvx(logic [1:0] c, logic [1:0] mx, logic [2:0] old);
    return (c <= mx) ? 3'(1 << c) : old;
  endfunction
  function automatic logic [31:0] mexp(logic e, logic h, logic [5:0] n);
    for (int i = 0; i < 32; i++)
      mexp[i] = e && (h ? i >= 16 : i < 16) && i < n;
  endfunction
  initial begin
    void'($urandom(2));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({tpv, lpv, fpv, subp, rdy}, {3'h1, 2'h1, 3'h1, 4'h8, 1'h1});
    wb(1'b0, 8'h3C, 32'h0, r);
    chk(r, 32'h0);
    for (int c = 0; c < 4; c++) begin
      d3 = $urandom & 32'h8000_5FFF;
      d3[30:25] = {c[1:0], c[1:0], c[1:0]};
      d3[11] = c[0];
      mode = 2'($urandom);
      u_cs.q.push_back(32'h7813_0005);
      u_cs.q.push_back(32'h0);
      u_cs.q.push_back({22'h0, mode, 8'h00});
      u_cs.q.push_back(d3);
      foreach (dep[i]) begin
        dep[i] = $urandom;
        u_cs.q.push_back(dep[i]);
      end
      drain;
      e_tri = pvx(c[1:0], 2'h2, e_tri);
      e_fan = pvx(c[1:0], 2'h2, e_fan);
      e_line = 2'(pvx(c[1:0], 2'h1, {1'b0, e_line}));
      chk({tpv, lpv, fpv}, {e_tri, e_line, e_fan});
      chk({ms, lp, aa, spw}, {mode, d3[31], d3[14], d3[10:0]});
      chk(subp, d3[12] ? 4'h4 : 4'h8);
      chk(dc, dep[0]);
      chk(ds, dep[1]);
      chk(dcl, dep[2]);
      @(posedge clk);
      vv <= 1'b1;
      vw <= 11'($urandom);
      thin <= 1'b1;
      lseg <= 1'b1;
      @(posedge clk);
      vv <= 1'b0;
      thin <= 1'b0;
      @(negedge clk);
      chk(pw, d3[11] ? d3[10:0] : vw);
      chk({light, spw}, {d3[31], d3[10:0]});
    end
    wb(1'b0, 8'h08, 32'h0, r);
    chk(r, d3);
    wb(1'b0, 8'h14, 32'h0, r);
    chk(r, dep[2]);
    u_cs.q.push_back(32'h7855_0002);
    repeat (3) u_cs.q.push_back($urandom);
    drain;
    chk(err, 1'b1);
    wb(1'b0, 8'h04, 32'h0, r);
    chk(r, 32'h0000_0101);
    wb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0000_0005);
    wb(1'b1, 8'h00, 32'h0, r);
    chk(rdy, 1'b0);
    wb(1'b1, 8'h00, 32'h3, r);
    chk(err, 1'b0);
    chk(rdy, 1'b1);
    for (int b = 0; b < 6; b++) begin
      na = (b == 0) ? 6'h10 : (b == 1) ? 6'h00 : 6'($urandom_range(32));
      en = (b < 2) ? 1'b1 : 1'($urandom);
      hf = (na >= 16) ? ((b == 0) ? 1'b1 : 1'($urandom)) : 1'b0;
      org = 1'($urandom);
      u_cs.q.push_back(32'h781F_000C);
      u_cs.q.push_back({3'h0, hf, na, en, org, 20'h0});
      repeat (12) u_cs.q.push_back($urandom);
      drain;
      chk({nao, se, sh, so}, {na, en, hf, org});
      chk(mask, mexp(en, hf, na));
      wb(1'b0, 8'h18, 32'h0, r);
      chk(r, {3'h0, hf, na, en, org, 20'h0});
    end
    finish_test;
  end
endmodule // ssd_decoder_tb
`default_nettype wire
